/* File: pkg/pam_defines.svh */
// constants for the port A alternate function multiplexer
`ifndef PAM_DEFINES_SVH
`define PAM_DEFINES_SVH

`define PAM_NPINS      6
`define PAM_PIN_XIN    0
`define PAM_PIN_XOUT   1
// select codes {low,high}: the low select bit is the upper code bit
`define PAM_CODE_00    2'h0
`define PAM_CODE_01    2'h1
`define PAM_CODE_10    2'h2
`define PAM_CODE_11    2'h3

`endif

/* File: pkg/pam_pkg.sv */
// types shared by the port A alternate function multiplexer
package pam_pkg;

  // peripheral-side signals driven toward the pins
  typedef struct packed {
    logic t0_out;     // timer 0 output
    logic t1_out;     // timer 1 output
    logic de0;        // uart 0 driver enable
    logic uart0_transmit_line;       // uart 0 transmit
    logic comparator_result_pin;       // comparator result
    logic xtal_out;   // crystal oscillator drive
  } pam_periph_out_t;

  // pin values delivered to peripheral inputs
  typedef struct packed {
    logic t0_in;      // timer 0 input
    logic t1_in;      // timer 1 input
    logic clk_in;     // external clock input
    logic rst_in;     // external reset input
    logic uart0_clear_to_send;       // uart 0 clear to send
    logic uart0_receive_line;       // uart 0 receive
    logic xtal_in;    // crystal oscillator input
  } pam_periph_in_t;

  // analog switch enables per function
  typedef struct packed {
    logic adc_vref_p1;  // adc input/reference on pin 1
    logic adc_in_p3;    // adc input on pin 3
    logic ana_neg_p4;   // adc/comparator negative on pin 4
    logic ana_pos_p5;   // adc/comparator positive on pin 5
  } pam_analog_t;

endpackage : pam_pkg

/* File: verilog/pam_pin_slice.sv */
// one pin's gpio/alternate output and direction selection
`timescale 1ns/10ps
module pam_pin_slice (
  input  wire logic gpio_out_i,   // port output data bit
  input  wire logic gpio_oe_i,    // port direction: 1 drives
  input  wire logic af_en_i,      // alternate function enable
  input  wire logic af_valid_i,   // select code maps a peripheral
  input  wire logic af_out_i,     // peripheral output value
  input  wire logic af_oe_i,      // peripheral direction
  output logic      pin_out_o,    // resolved pin output value
  output logic      pin_oe_o      // resolved pin output enable
);
  // reserved codes leave the pin undriven and unowned
  always_comb begin
    if (af_en_i) begin
      pin_out_o = af_valid_i & af_out_i;
      pin_oe_o  = af_valid_i & af_oe_i;
    end else begin
      pin_out_o = gpio_out_i;
      pin_oe_o  = gpio_oe_i;
    end
  end
endmodule : pam_pin_slice

/* File: verilog/pam_port_mux.sv */
// port A alternate function multiplexer, six pins
`timescale 1ns/10ps
`include "pam_defines.svh"

// Operation
// R01: per-pin enable picks gpio or alternate
// R02: alternate mode gives direction to peripheral
// R03: code is {low select bit, high select bit}
// R04: crystal enable overrides pins 0 and 1
// R05: pin0 t0 in/~t0 out; pin1 t0, clk, adc
// R06: pin2 de0, reset in, t1 out
// R07: pin3 uart0_clear_to_send, comparator out, t1 in, adc
// R08: pin4 uart0_receive_line or analog negative input
// R09: pin5 uart0_transmit_line, ~t1 out, analog positive
// R10: analog needs enable plus matching code
// R11: reserved codes connect no peripheral
module pam_port_mux
  import pam_pkg::*;
#(
  parameter int NPINS = `PAM_NPINS    // pins served
) (
  input  wire logic             mclk_i,          // system clock
  input  wire logic             sys_rst_i,       // async reset, high
  input  wire logic [NPINS-1:0] af_enable_i,     // alt enable per pin
  input  wire logic [NPINS-1:0] function_select_low_i,  // low code bit
  input  wire logic [NPINS-1:0] function_select_high_i, // high code bit
  input  wire logic [NPINS-1:0] gpio_out_i,      // port data out
  input  wire logic [NPINS-1:0] gpio_dir_out_i,  // 1 = output
  input  wire logic             xtal_en_i,       // crystal enabled
  input  wire logic             t0_oe_i,         // timer0 drives pin
  input  wire logic             t1_oe_i,         // timer1 drives pin
  input  wire pam_periph_out_t  periph_i,        // peripheral outputs
  input  wire logic [NPINS-1:0] pin_in_i,        // pad input levels
  output pam_periph_in_t        periph_o,        // peripheral inputs
  output pam_analog_t           analog_o,        // analog switches
  output logic [NPINS-1:0]      pin_out_o,       // pad output values
  output logic [NPINS-1:0]      pin_oe_o         // pad drive enables
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  // the function table is fixed to six pins
  if (NPINS != `PAM_NPINS) begin : g_bad_npins
    $error("pam_port_mux supports exactly six pins");
  end

  // ------------------------------------------------------------
  // select codes
  // ------------------------------------------------------------
  logic [1:0] code [NPINS];   // per-pin function code
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      code[i] = {function_select_low_i[i], function_select_high_i[i]}; // [R03]
    end
  end

  // ------------------------------------------------------------
  // per-pin alternate output, direction and validity
  // ------------------------------------------------------------
  logic [NPINS-1:0] af_out;    // peripheral value per pin
  logic [NPINS-1:0] af_oe;     // peripheral direction per pin
  logic [NPINS-1:0] af_valid;  // code names a peripheral
  always_comb begin
    af_out   = '0;
    af_oe    = '0;
    af_valid = '0;
    // pin 0: timer0 input or inverted timer0 output
    case (code[0])
      `PAM_CODE_00: af_valid[0] = 1'b1;                 // [R05]
      `PAM_CODE_11: begin                               // [R05]
        af_valid[0] = 1'b1;
        af_out[0]   = ~periph_i.t0_out;
        af_oe[0]    = t0_oe_i;
      end
      default: af_valid[0] = 1'b0;                      // [R11]
    endcase
    // pin 1: timer0 output, clock input, analog
    case (code[1])
      `PAM_CODE_00: begin                               // [R05]
        af_valid[1] = 1'b1;
        af_out[1]   = periph_i.t0_out;
        af_oe[1]    = t0_oe_i;
      end
      `PAM_CODE_10: af_valid[1] = 1'b1;
      `PAM_CODE_11: af_valid[1] = 1'b1;                 // analog: undriven
      default:      af_valid[1] = 1'b0;                 // [R11]
    endcase
    // pin 2: driver enable, reset input, timer1 output
    case (code[2])
      `PAM_CODE_00: begin                               // [R06]
        af_valid[2] = 1'b1;
        af_out[2]   = periph_i.de0;
        af_oe[2]    = 1'b1;
      end
      `PAM_CODE_01: af_valid[2] = 1'b1;                 // reset input
      `PAM_CODE_10: begin                               // [R06]
        af_valid[2] = 1'b1;
        af_out[2]   = periph_i.t1_out;
        af_oe[2]    = t1_oe_i;
      end
      default: af_valid[2] = 1'b0;                      // [R11]
    endcase
    // pin 3: clear to send, comparator, timer1 input, adc
    case (code[3])
      `PAM_CODE_01: begin                               // [R07]
        af_valid[3] = 1'b1;
        af_out[3]   = periph_i.comparator_result_pin;
        af_oe[3]    = 1'b1;
      end
      default: af_valid[3] = 1'b1;                      // all codes used
    endcase
    // pin 4: receive data or negative analog input
    case (code[4])
      `PAM_CODE_00: af_valid[4] = 1'b1;                 // [R08]
      `PAM_CODE_11: af_valid[4] = 1'b1;                 // [R08]
      default:      af_valid[4] = 1'b0;                 // [R11]
    endcase
    // pin 5: transmit, inverted timer1, positive analog
    case (code[5])
      `PAM_CODE_00: begin                               // [R09]
        af_valid[5] = 1'b1;
        af_out[5]   = periph_i.uart0_transmit_line;
        af_oe[5]    = 1'b1;
      end
      `PAM_CODE_01: begin                               // [R09]
        af_valid[5] = 1'b1;
        af_out[5]   = ~periph_i.t1_out;
        af_oe[5]    = t1_oe_i;
      end
      `PAM_CODE_11: af_valid[5] = 1'b1;
      default:      af_valid[5] = 1'b0;                 // [R11]
    endcase
  end

  // ------------------------------------------------------------
  // pad resolution, one slice per pin
  // ------------------------------------------------------------
  logic [NPINS-1:0] mux_out;   // slice output value
  logic [NPINS-1:0] mux_oe;    // slice output enable
  for (genvar g = 0; g < NPINS; g++) begin : g_slice
    pam_pin_slice u_slice (
      .gpio_out_i (gpio_out_i[g]),
      .gpio_oe_i  (gpio_dir_out_i[g]),
      .af_en_i    (af_enable_i[g]),                     // [R01]
      .af_valid_i (af_valid[g]),
      .af_out_i   (af_out[g]),
      .af_oe_i    (af_oe[g]),                           // [R02]
      .pin_out_o  (mux_out[g]),
      .pin_oe_o   (mux_oe[g])
    );
  end

  // ------------------------------------------------------------
  // next-state computation
  // ------------------------------------------------------------
  logic [NPINS-1:0] pin_out_d, pin_oe_d;  // pad next values
  pam_periph_in_t   periph_d;             // peripheral input next
  pam_analog_t      analog_d;             // analog switch next
  always_comb begin
    pin_out_d = mux_out;
    pin_oe_d  = mux_oe;
    // crystal takes pins 0 and 1 whatever the port says
    if (xtal_en_i) begin                                // [R04]
      pin_out_d[`PAM_PIN_XIN]  = 1'b0;
      pin_oe_d[`PAM_PIN_XIN]   = 1'b0;
      pin_out_d[`PAM_PIN_XOUT] = periph_i.xtal_out;
      pin_oe_d[`PAM_PIN_XOUT]  = 1'b1;
    end
    // peripheral inputs only see the pin when routed to them
    periph_d.t0_in  = af_enable_i[0] && code[0] == `PAM_CODE_00
                      && !xtal_en_i && pin_in_i[0];     // [R05]
    periph_d.clk_in = af_enable_i[1] && code[1] == `PAM_CODE_10
                      && !xtal_en_i && pin_in_i[1];     // [R05]
    periph_d.rst_in = af_enable_i[2] && code[2] == `PAM_CODE_01
                      && pin_in_i[2];                   // [R06]
    periph_d.uart0_clear_to_send   = af_enable_i[3] && code[3] == `PAM_CODE_00
                      && pin_in_i[3];                   // [R07]
    periph_d.t1_in  = af_enable_i[3] && code[3] == `PAM_CODE_10
                      && pin_in_i[3];                   // [R07]
    periph_d.uart0_receive_line   = af_enable_i[4] && code[4] == `PAM_CODE_00
                      && pin_in_i[4];                   // [R08]
    periph_d.xtal_in = xtal_en_i && pin_in_i[`PAM_PIN_XIN]; // [R04]
    // analog switches need enable and matching code
    analog_d.adc_vref_p1 = af_enable_i[1] && !xtal_en_i
                           && code[1] == `PAM_CODE_11;  // [R10]
    analog_d.adc_in_p3   = af_enable_i[3]
                           && code[3] == `PAM_CODE_11;  // [R10]
    analog_d.ana_neg_p4  = af_enable_i[4]
                           && code[4] == `PAM_CODE_11;  // [R10]
    analog_d.ana_pos_p5  = af_enable_i[5]
                           && code[5] == `PAM_CODE_11;  // [R10]
  end

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  // registering costs one cycle of latency but gives clean pads
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_out_o <= '0;
      pin_oe_o  <= '0;
      periph_o  <= '0;
      analog_o  <= '0;
    end else begin
      pin_out_o <= pin_out_d;
      pin_oe_o  <= pin_oe_d;
      periph_o  <= periph_d;
      analog_o  <= analog_d;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_gpio_pass: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !af_enable_i[2] |=> pin_oe_o[2] == $past(gpio_dir_out_i[2])) // [R01]
    else $error("pin 2 gpio direction not passed");
  chk_af_dir: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    af_enable_i[5] && code[5] == `PAM_CODE_00 |=> pin_oe_o[5]) // [R02]
    else $error("pin 5 transmit not driving");
  chk_code_bits: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    af_enable_i[3] && function_select_high_i[3] && !function_select_low_i[3]
    |=> pin_out_o[3] == $past(periph_i.comparator_result_pin)) // [R03]
    else $error("pin 3 code bits misread");
  chk_xtal_ovr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    xtal_en_i |=> pin_oe_o[1] && !pin_oe_o[0] && !periph_o.t0_in) // [R04]
    else $error("crystal override missing");
  chk_t0_inv: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    af_enable_i[0] && code[0] == `PAM_CODE_11 && !xtal_en_i
    |=> pin_out_o[0] != $past(periph_i.t0_out)) // [R05]
    else $error("pin 0 timer output not inverted");
  chk_rst_route: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    periph_o.rst_in |-> $past(code[2]) == `PAM_CODE_01) // [R06]
    else $error("reset input routed on wrong code");
  chk_t1_in: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    periph_o.t1_in |-> $past(af_enable_i[3] && pin_in_i[3])) // [R07]
    else $error("timer1 input without routing");
  chk_rx_route: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    periph_o.uart0_receive_line |-> $past(code[4]) == `PAM_CODE_00) // [R08]
    else $error("receive routed on wrong code");
  chk_t1_cmp: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    af_enable_i[5] && code[5] == `PAM_CODE_01
    |=> pin_out_o[5] != $past(periph_i.t1_out)) // [R09]
    else $error("pin 5 timer1 not inverted");
  chk_ana_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !af_enable_i[4] |=> !analog_o.ana_neg_p4) // [R10]
    else $error("analog switch without enable");
  chk_rsv_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    af_enable_i[4] && code[4] == `PAM_CODE_01
    |=> !pin_oe_o[4] && !periph_o.uart0_receive_line) // [R11]
    else $error("reserved code connected something");

  cov_xtal: cover property (@(posedge mclk_i) xtal_en_i ##1 pin_oe_o[1]);
  cov_tx: cover property (@(posedge mclk_i) pin_oe_o[5] && af_enable_i[5]);
  cov_ana: cover property (@(posedge mclk_i) analog_o.ana_pos_p5);
  cov_rst: cover property (@(posedge mclk_i) periph_o.rst_in);

endmodule : pam_port_mux

/* File: verif/pam_periph_model.sv */
// behavioural model of the peripherals that face the port A mux
`timescale 1ns/10ps
module pam_periph_model
  import pam_pkg::*;
(
  input  wire logic       mclk_i,    // system clock
  input  wire logic       sys_rst_i, // async reset, high
  input  wire logic [3:0] pace_i,    // idle cycles between changes
  output pam_periph_out_t periph_o,  // peripheral drive values
  output logic            t0_oe_o,   // timer 0 wants its pin driven
  output logic            t1_oe_o    // timer 1 wants its pin driven
);
  logic [3:0] wait_q; // cycles left before the next change

  // ---------------------------------------------------------------
  // peripheral activity
  // ---------------------------------------------------------------
  // a slow peripheral holds its levels for pace_i+1 cycles, so the mux
  // is also seen with stable drive and not only with fresh values
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_q <= 4'h0;
      {periph_o, t0_oe_o, t1_oe_o} <= 8'h00;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1; // still holding
    end else begin
      wait_q <= pace_i;
      {periph_o, t0_oe_o, t1_oe_o} <= 8'($urandom);
    end
  end
endmodule : pam_periph_model

/* File: verif/port_alt_function_mux_tb_top.sv */
// self-checking testbench for the port A alternate function mux
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin \
  bad_count++; $display("wrong value %s exp %h got %h", nm, e, s); \
  end end
module port_alt_function_mux_tb_top;
  import pam_pkg::*;
  typedef struct packed {
    pam_periph_in_t pi;  // expected peripheral inputs
    pam_analog_t    an;  // expected analog switches
    logic [5:0]     out; // expected pad values
    logic [5:0]     oe;  // expected pad enables
  } pam_exp_t;
  logic mclk_i, sys_rst_i, xtal_en, t0_oe, t1_oe;
  logic [5:0] af_en, sel_lo, sel_hi, gpio_out, gpio_dir, pin_in;
  logic [5:0] pin_out_o, pin_oe_o;
  logic [3:0] pace;
  pam_periph_out_t po;
  pam_periph_in_t  periph_o;
  pam_analog_t     analog_o;
  pam_exp_t        exp_q[$];
  pam_exp_t        e;
  int bad_count = 0;
  int n_checks = 0;

  pam_port_mux dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .af_enable_i(af_en), .function_select_low_i(sel_lo),
    .function_select_high_i(sel_hi), .gpio_out_i(gpio_out),
    .gpio_dir_out_i(gpio_dir), .xtal_en_i(xtal_en), .t0_oe_i(t0_oe),
    .t1_oe_i(t1_oe), .periph_i(po), .pin_in_i(pin_in),
    .periph_o(periph_o), .analog_o(analog_o), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o));
  pam_periph_model part_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .pace_i(pace), .periph_o(po), .t0_oe_o(t0_oe), .t1_oe_o(t1_oe));

  // ---------------------------------------------------------------
  // reference of the routing, worked out from the pin table
  // ---------------------------------------------------------------
  function automatic pam_exp_t model();
    pam_exp_t r;
    logic p;
    r = '0;
    for (int n = 0; n < 6; n++) begin
      p = pin_in[n];
      {r.oe[n], r.out[n]} = {gpio_dir[n], gpio_out[n]};
      if (af_en[n]) begin
        {r.oe[n], r.out[n]} = 2'h0; // reserved codes stay idle
        case ({n[2:0], sel_lo[n], sel_hi[n]})
          5'h00: r.pi.t0_in = p;
          5'h03: {r.oe[n], r.out[n]} = {t0_oe, ~po.t0_out};
          5'h04: {r.oe[n], r.out[n]} = {t0_oe, po.t0_out};
          5'h06: r.pi.clk_in = p;
          5'h07: r.an.adc_vref_p1 = 1'b1;
          5'h08: {r.oe[n], r.out[n]} = {1'b1, po.de0};
          5'h09: r.pi.rst_in = p;
          5'h0A: {r.oe[n], r.out[n]} = {t1_oe, po.t1_out};
          5'h0C: r.pi.uart0_clear_to_send = p;
          5'h0D: {r.oe[n], r.out[n]} = {1'b1, po.comparator_result_pin};
          5'h0E: r.pi.t1_in = p;
          5'h0F: r.an.adc_in_p3 = 1'b1;
          5'h10: r.pi.uart0_receive_line = p;
          5'h13: r.an.ana_neg_p4 = 1'b1;
          5'h14: {r.oe[n], r.out[n]} = {1'b1, po.uart0_transmit_line};
          5'h15: {r.oe[n], r.out[n]} = {t1_oe, ~po.t1_out};
          5'h17: r.an.ana_pos_p5 = 1'b1;
          default: ; // nothing routed
        endcase
      end
    end
    if (xtal_en) begin // crystal takes pins 0 and 1
      {r.oe[1:0], r.out[1:0]} = {2'b10, po.xtal_out, 1'b0};
      r.pi.xtal_in = pin_in[0];
      {r.pi.t0_in, r.pi.clk_in, r.an.adc_vref_p1} = 3'h0;
    end
    return r;
  endfunction : model

  // one cycle of stimulus, noted once every input has landed
  task automatic drive(input logic [17:0] sel, input logic xt);
    @(posedge mclk_i);
    {af_en, sel_hi, sel_lo} <= sel;
    xtal_en <= xt;
    {gpio_out, gpio_dir, pin_in} <= 18'($urandom);
    #1;
    exp_q.push_back(model());
  endtask : drive

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // clock, watchdog, output watcher
  // ---------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (2000) @(posedge mclk_i);
    bad_count++; // hang
    wrap_up();
  end

  // outputs lag by one edge, so the oldest note is due once a newer
  // one exists
  initial begin
    forever begin
      @(posedge mclk_i);
      #2;
      if (exp_q.size() > 1) begin
        e = exp_q.pop_front();
        `CHK("periph_o", e.pi, periph_o)
        `CHK("analog_o", e.an, analog_o)
        `CHK("pin_oe_o", e.oe, pin_oe_o)
        `CHK("pin_out_o", e.out & e.oe, pin_out_o & e.oe)
      end
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h72494D5D));
    sys_rst_i = 1'b1;
    {af_en, sel_lo, sel_hi, gpio_out, gpio_dir, pin_in} = '0;
    {xtal_en, pace} = 5'h00;
    repeat (6) @(posedge mclk_i);
    `CHK("reset", 23'h000000, {periph_o, analog_o, pin_oe_o, pin_out_o})
    sys_rst_i <= 1'b0;
    // every code on every pin, enabled and not, crystal off and on
    for (int k = 0; k < 16; k++) begin
      drive({{6{k[2]}}, {6{k[1]}}, {6{k[0]}}}, k[3]);
    end
    // random mix with a slow partner now and then
    for (int k = 0; k < 400; k++) begin
      pace <= 4'($urandom % 3);
      drive(18'($urandom), ($urandom % 8) == 0);
    end
    repeat (3) @(posedge mclk_i);
    wrap_up();
  end
endmodule : port_alt_function_mux_tb_top
